// file: drive_process_data_status.sv
/*
  Process-data mapping and status-word flag logic of a positioning drive.
  Software (scanner side) writes the output assembly over APB and reads the
  input assembly back. Motion events come from the motion core as pulses and
  levels. Assumes pclk at 50 MHz, all inputs synchronous to pclk.
*/
// How it works
// RULE1: Output assembly: control 0-1, unused 2-3, target 4-7, param id/index/value 8-15.
// RULE2: Input assembly: status 0-1, speed 2-3, position 4-7, param answer 8-15.
// RULE3: Without parameter interface both assemblies are 8 bytes, param words inert.
// RULE4: Scanner sets output and input size selections the same.
// RULE5: Target-reached set on successful arrival or readjusted displacement within window.
// RULE6: Target-reached cleared on far new target, manual run, bad target, rotation.
// RULE7: Drag error set when following error exceeds limit outside braking.
// RULE8: Drag error and run aborted cleared on new run or acknowledge rising edge.
// RULE9: Status bits 2 and 3 follow reverse and forward jog keys.
// RULE10: Power bit set while supply above undervoltage limit and below 30V.
// RULE11: Run-aborted set when release withdrawn or control bits invalid during run.
// RULE12: Running bit follows rotation, clear at standstill.
// RULE13: Over-temperature set above limit, cleared 5 degC below limit.
// RULE14: Scanner acknowledges errors with 0-to-1 edge on control bit 14.
// RULE15: Runs start only with release set; clearing release aborts the run.
// RULE16: Status, speed and position refreshed in input assembly every exchange.
`timescale 1ns/1ps
module drive_process_data_status (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Motion core events and levels
  input  wire logic        run_request,
  input  wire logic        manual_run,
  input  wire logic        target_arrived,
  input  wire logic        invalid_target,
  input  wire logic        invalid_bits,
  input  wire logic        run_active,
  input  wire logic        braking,
  input  wire logic        rotating,
  input  wire logic        standstill_turned,
  input  wire logic        readjust_active,
  input  wire logic [31:0] commanded_pos,
  input  wire logic [31:0] actual_pos,
  input  wire logic [15:0] actual_speed,
  // Parameter answer from the parameter engine
  input  wire logic [31:0] answer_id_idx,
  input  wire logic [31:0] answer_value,
  // Keys and analogue readings
  input  wire logic        rev_key,
  input  wire logic        fwd_key,
  input  wire logic [15:0] supply_mv,
  input  wire logic [15:0] temp_c,
  // To motion core, plus status word and interrupt
  output logic      [15:0] control_word,
  output logic      [31:0] target_value,
  output logic      [31:0] param_id_idx,
  output logic      [31:0] param_value,
  output logic             run_start,
  output logic             run_abort,
  output logic      [15:0] status_word,
  output logic             irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0]               control;
    logic [31:0]               target;
    logic [31:0]               pid_idx;
    logic [31:0]               pvalue;
    logic [31:0]               config_w;  // [0] out size, [1] in size
    logic [15:0]               pos_window;
    logic [15:0]               drag_limit;
    logic [15:0]               undervolt;
    logic [15:0]               temp_limit;
    logic [pd_status_pkg::ST_FLAGS-1:0] flags;
    logic [pd_status_pkg::ST_FLAGS-1:0] irq_status;
    logic [pd_status_pkg::ST_FLAGS-1:0] irq_mask;
    logic                      ack_prev;
    logic [1:0]                refresh_idx;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic        wr_acc;
  logic        rd_acc;
  logic        param_on;
  logic [31:0] pos_diff;
  logic [31:0] follow_err;
  logic        ack_edge;
  logic        run_go;
  logic        abort_go;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic [1:0]  mem_raddr;
  logic        mem_sel;
  logic [pd_status_pkg::ST_FLAGS-1:0] flags_n;

  // Absolute difference of two positions
  function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
    logic signed [32:0] d;
    d = $signed({a[31], a}) - $signed({b[31], b});
    abs_diff = d[32] ? 32'(-d) : d[31:0];
  endfunction : abs_diff

  // ****************************************************************
  // Bus decode and derived terms
  // ****************************************************************
  assign wr_acc     = psel && penable && pwrite;
  assign rd_acc     = psel && penable && !pwrite;
  assign pready     = 1'b1;
  assign param_on   = state_reg.config_w[0] && state_reg.config_w[1];  // see RULE3 see RULE4
  assign pos_diff   = abs_diff(state_reg.target, actual_pos);
  assign follow_err = abs_diff(commanded_pos, actual_pos);
  assign ack_edge   = state_reg.control[pd_status_pkg::CW_ERR_ACK] && !state_reg.ack_prev; // see RULE14
  assign run_go     = run_request && state_reg.control[pd_status_pkg::CW_RELEASE]; // see RULE15
  assign abort_go   = run_active && (!state_reg.control[pd_status_pkg::CW_RELEASE]
                      || invalid_bits);                              // see RULE15
  assign run_start  = run_go;
  assign run_abort  = abort_go;

  // Flag set and clear; set beats clear where both occur, but manual run beats arrival and standstill turn beats readjust set
  always_comb
  begin
    flags_n = state_reg.flags;
    if (manual_run || invalid_target || standstill_turned
        || (wr_acc && paddr == pd_status_pkg::OFF_TARGET
            && state_reg.control[pd_status_pkg::CW_TRANSFER]
            && abs_diff(pwdata, actual_pos) > {16'h0000, state_reg.pos_window}))
    begin
      flags_n[pd_status_pkg::ST_TARGET_REACHED] = 1'b0;                // see RULE6
    end
    if ((target_arrived && !manual_run)
        || (readjust_active && !rotating && pos_diff <= {16'h0000, state_reg.pos_window}
            && !state_reg.flags[pd_status_pkg::ST_TARGET_REACHED] && !standstill_turned))
    begin
      flags_n[pd_status_pkg::ST_TARGET_REACHED] = 1'b1;                // see RULE5
    end
    if (run_go || ack_edge)
    begin
      flags_n[pd_status_pkg::ST_DRAG_ERROR]  = 1'b0;                   // see RULE8
      flags_n[pd_status_pkg::ST_RUN_ABORTED] = 1'b0;                   // see RULE8
    end
    if (run_active && !braking && follow_err > {16'h0000, state_reg.drag_limit})
    begin
      flags_n[pd_status_pkg::ST_DRAG_ERROR] = 1'b1;                    // see RULE7
    end
    if (abort_go)
    begin
      flags_n[pd_status_pkg::ST_RUN_ABORTED] = 1'b1;                   // see RULE11
    end
    flags_n[pd_status_pkg::ST_REV_KEY] = rev_key;                      // see RULE9
    flags_n[pd_status_pkg::ST_FWD_KEY] = fwd_key;                      // see RULE9
    flags_n[pd_status_pkg::ST_POWER_OK] = (supply_mv > state_reg.undervolt)
                                          && (supply_mv < pd_status_pkg::SUPPLY_MAX_MV); // see RULE10
    flags_n[pd_status_pkg::ST_RUNNING] = rotating;                     // see RULE12
    if (temp_c > state_reg.temp_limit)
    begin
      flags_n[pd_status_pkg::ST_OVER_TEMP] = 1'b1;                     // see RULE13
    end
    else if (temp_c + pd_status_pkg::TEMP_HYST_C <= state_reg.temp_limit)
    begin
      flags_n[pd_status_pkg::ST_OVER_TEMP] = 1'b0;                     // see RULE13
    end
  end

  // ****************************************************************
  // Register update
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    state_next.flags = flags_n;
    state_next.ack_prev = state_reg.control[pd_status_pkg::CW_ERR_ACK];
    state_next.refresh_idx = state_reg.refresh_idx + 2'h1;
    // Sticky interrupt bits on rising flags; write-one clears, set wins
    if (wr_acc && paddr == pd_status_pkg::OFF_IRQ_STATUS)
    begin
      state_next.irq_status = state_reg.irq_status & ~pwdata[pd_status_pkg::ST_FLAGS-1:0];
    end
    state_next.irq_status = state_next.irq_status | (flags_n & ~state_reg.flags);
    if (wr_acc)
    begin
      unique case (paddr)
        pd_status_pkg::OFF_CONTROL:      state_next.control    = pwdata[15:0];  // see RULE1
        pd_status_pkg::OFF_TARGET:       state_next.target     = pwdata;        // see RULE1
        pd_status_pkg::OFF_PARAM_ID_IDX: state_next.pid_idx   =
          param_on ? pwdata : state_reg.pid_idx;                              // see RULE3
        pd_status_pkg::OFF_PARAM_VALUE:  state_next.pvalue    =
          param_on ? pwdata : state_reg.pvalue;                               // see RULE3
        pd_status_pkg::OFF_CONFIG:       state_next.config_w   = pwdata;
        pd_status_pkg::OFF_LIMITS:       {state_next.drag_limit, state_next.pos_window} = pwdata;
        pd_status_pkg::OFF_ACTUAL_SPEED: state_next.undervolt  = pwdata[15:0];
        pd_status_pkg::OFF_ACTUAL_POS:   state_next.temp_limit = pwdata[15:0];
        pd_status_pkg::OFF_IRQ_MASK:     state_next.irq_mask = pwdata[pd_status_pkg::ST_FLAGS-1:0];
        default:                         state_next.control    = state_reg.control;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg            <= '0;
      state_reg.config_w   <= pd_status_pkg::RST_CONFIG;
      state_reg.pos_window <= pd_status_pkg::RST_POS_WINDOW;
      state_reg.drag_limit <= pd_status_pkg::RST_DRAG_LIMIT;
      state_reg.undervolt  <= pd_status_pkg::RST_UNDERVOLT_MV;
      state_reg.temp_limit <= pd_status_pkg::RST_TEMP_LIMIT_C;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Input assembly, refreshed word by word every cycle
  // ****************************************************************
  always_comb
  begin
    unique case (state_reg.refresh_idx)
      2'h0:    mem_wdata = {actual_speed, 8'h00, state_reg.flags};          // see RULE2
      2'h1:    mem_wdata = actual_pos;                                      // see RULE2
      2'h2:    mem_wdata = param_on ? answer_id_idx : 32'h0000_0000;        // see RULE3
      default: mem_wdata = param_on ? answer_value : 32'h0000_0000;         // see RULE3
    endcase
  end

  // Offsets from the speed word up select input assembly words 0 to 3
  assign mem_sel   = (paddr >= pd_status_pkg::OFF_STATUS)
                     && (paddr <= pd_status_pkg::OFF_ANS_VALUE);
  assign mem_raddr = 2'(paddr[7:2] - pd_status_pkg::OFF_ACTUAL_SPEED[7:2]);

  pd_word_mem u_input_asm (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (1'b1),                                                       // see RULE16
    .wr_addr (state_reg.refresh_idx),
    .wr_data (mem_wdata),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata)
  );

  // Read mux; parameter answer words come through the memory, others direct
  always_comb
  begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (rd_acc)
    begin
      unique case (paddr)
        pd_status_pkg::OFF_CONTROL:      prdata = {16'h0000, state_reg.control};
        pd_status_pkg::OFF_TARGET:       prdata = state_reg.target;
        pd_status_pkg::OFF_PARAM_ID_IDX: prdata = state_reg.pid_idx;
        pd_status_pkg::OFF_PARAM_VALUE:  prdata = state_reg.pvalue;
        pd_status_pkg::OFF_STATUS:       prdata = {16'h0000, 8'h00, state_reg.flags};
        pd_status_pkg::OFF_ACTUAL_SPEED: prdata = {16'h0000, actual_speed};
        pd_status_pkg::OFF_ACTUAL_POS:   prdata = actual_pos;
        pd_status_pkg::OFF_ANS_ID_IDX:   prdata = mem_rdata;                // see RULE2
        pd_status_pkg::OFF_ANS_VALUE:    prdata = mem_rdata;                // see RULE2
        pd_status_pkg::OFF_CONFIG:       prdata = state_reg.config_w;
        pd_status_pkg::OFF_LIMITS:       prdata = {state_reg.drag_limit, state_reg.pos_window};
        pd_status_pkg::OFF_IRQ_STATUS:   prdata = {24'h000000, state_reg.irq_status};
        pd_status_pkg::OFF_IRQ_MASK:     prdata = {24'h000000, state_reg.irq_mask};
        default:                         pslverr = !mem_sel;
      endcase
    end
  end

  // Outputs
  assign control_word = state_reg.control;
  assign target_value = state_reg.target;
  assign param_id_idx = state_reg.pid_idx;
  assign param_value  = state_reg.pvalue;
  assign status_word  = {8'h00, state_reg.flags};
  assign irq          = |(state_reg.irq_status & state_reg.irq_mask);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  drag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_active && !braking && follow_err > {16'h0000, state_reg.drag_limit}
    |=> status_word[pd_status_pkg::ST_DRAG_ERROR]) // see RULE7
    else $error("drag error not set");

  ack_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    ack_edge && !(run_active && !braking && follow_err > {16'h0000, state_reg.drag_limit})
    |=> !status_word[pd_status_pkg::ST_DRAG_ERROR]) // see RULE8
    else $error("drag error not cleared by acknowledge");

  key_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 status_word[pd_status_pkg::ST_REV_KEY] == $past(rev_key)
    && status_word[pd_status_pkg::ST_FWD_KEY] == $past(fwd_key)) // see RULE9
    else $error("key bits do not follow keys");

  power_band_a: assert property (@(posedge pclk) disable iff (!presetn)
    supply_mv >= pd_status_pkg::SUPPLY_MAX_MV |=> !status_word[pd_status_pkg::ST_POWER_OK]) // see RULE10
    else $error("power bit set above 30V");

  abort_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_active && !control_word[pd_status_pkg::CW_RELEASE]
    |-> run_abort ##1 status_word[pd_status_pkg::ST_RUN_ABORTED]) // see RULE11
    else $error("run abort not flagged");

  running_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rotating) |=> status_word[pd_status_pkg::ST_RUNNING]) // see RULE12
    else $error("running bit missed rotation");

  temp_hyst_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[pd_status_pkg::ST_OVER_TEMP] && temp_c + pd_status_pkg::TEMP_HYST_C
    > state_reg.temp_limit |=> status_word[pd_status_pkg::ST_OVER_TEMP]) // see RULE13
    else $error("over-temperature cleared inside hysteresis");

  reach_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    target_arrived && !manual_run |=> status_word[pd_status_pkg::ST_TARGET_REACHED]) // see RULE5
    else $error("target reached not set");

  reach_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    manual_run && !target_arrived |=> !status_word[pd_status_pkg::ST_TARGET_REACHED]) // see RULE6
    else $error("target reached not cleared by manual run");

  release_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_start |-> control_word[pd_status_pkg::CW_RELEASE]) // see RULE15
    else $error("run started without release");

endmodule : drive_process_data_status

// file: pd_status_pkg.sv
/*
  Package for the process-data and status-word block of a positioning drive.
  Holds APB offsets, assembly byte layout, status bit positions and control
  bit positions. Assumes a 32-bit APB bus and a single clock domain.
*/
package pd_status_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFF_CONTROL      = 8'h00;
  localparam logic [7:0] OFF_TARGET       = 8'h04;
  localparam logic [7:0] OFF_PARAM_ID_IDX = 8'h08;
  localparam logic [7:0] OFF_PARAM_VALUE  = 8'h0C;
  localparam logic [7:0] OFF_STATUS       = 8'h10;
  localparam logic [7:0] OFF_ACTUAL_SPEED = 8'h14;
  localparam logic [7:0] OFF_ACTUAL_POS   = 8'h18;
  localparam logic [7:0] OFF_ANS_ID_IDX   = 8'h1C;
  localparam logic [7:0] OFF_ANS_VALUE    = 8'h20;
  localparam logic [7:0] OFF_CONFIG       = 8'h24;
  localparam logic [7:0] OFF_LIMITS       = 8'h28;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h2C;
  localparam logic [7:0] OFF_IRQ_MASK     = 8'h30;

  // ****************************************************************
  // Assembly layout
  // ****************************************************************
  localparam int ASM_FULL_BYTES  = 16;
  localparam int ASM_SHORT_BYTES = 8;
  localparam int ASM_WORDS       = 4;

  // ****************************************************************
  // Status word bits
  // ****************************************************************
  localparam int ST_TARGET_REACHED = 0;
  localparam int ST_DRAG_ERROR     = 1;
  localparam int ST_REV_KEY        = 2;
  localparam int ST_FWD_KEY        = 3;
  localparam int ST_POWER_OK       = 4;
  localparam int ST_RUN_ABORTED    = 5;
  localparam int ST_RUNNING        = 6;
  localparam int ST_OVER_TEMP      = 7;
  localparam int ST_FLAGS          = 8;

  // ****************************************************************
  // Control word bits
  // ****************************************************************
  localparam int CW_TRANSFER  = 2;
  localparam int CW_RELEASE   = 4;
  localparam int CW_ERR_ACK   = 14;

  // ****************************************************************
  // Analogue limits and reset values
  // ****************************************************************
  localparam logic [15:0] SUPPLY_MAX_MV     = 16'h7530; // 30 V
  localparam logic [15:0] TEMP_HYST_C       = 16'h0005; // 5 degC
  localparam logic [15:0] RST_POS_WINDOW    = 16'h000A;
  localparam logic [15:0] RST_DRAG_LIMIT    = 16'h0064;
  localparam logic [15:0] RST_UNDERVOLT_MV  = 16'h4E20;
  localparam logic [15:0] RST_TEMP_LIMIT_C  = 16'h0050;
  localparam logic [31:0] RST_CONFIG        = 32'h0000_0003;

endpackage : pd_status_pkg

// file: pd_word_mem.sv
/*
  Small register-read memory of four 32-bit words, used for the input
  assembly. Read data come from a register. Assumes one clock.
*/
`timescale 1ns/1ps
module pd_word_mem (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  // Read port
  input  wire logic [1:0]  rd_addr,
  output logic      [31:0] rd_data
);

  typedef struct packed {
    logic [3:0][31:0] words;
    logic [31:0]      rdata;
  } mem_s;

  mem_s state_reg;
  mem_s state_next;

  // Write and registered read
  always_comb
  begin
    state_next = state_reg;
    if (wr_en)
    begin
      state_next.words[wr_addr] = wr_data;
    end
    state_next.rdata = state_reg.words[rd_addr];
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rd_data = state_reg.rdata;

endmodule : pd_word_mem

// file: motion_core_model.sv
/*
  Motion core stand-in: starts and stops runs at a fixed position.
  Assumes the drive's run strobes in the pclk domain.
*/
`timescale 1ns/1ps
module motion_core_model (
  // Clock, reset and strobes
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run_start,
  input  wire logic        run_abort,
  input  wire logic        target_arrived,
  input  wire logic [31:0] drag_err,
  // Motion state
  output logic             run_active,
  output logic             rotating,
  output logic      [31:0] actual_pos,
  output logic      [31:0] commanded_pos
);
  // Run stops at once on abort or arrival
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      run_active <= 1'b0;
    else if (run_abort || target_arrived)
      run_active <= 1'b0;
    else if (run_start)
      run_active <= 1'b1;
  // Fixed position, command leads by the requested lag
  assign rotating      = run_active;
  assign actual_pos    = 32'h0000_1000;
  assign commanded_pos = actual_pos + drag_err;
endmodule : motion_core_model

// file: tb_drive_process_data_status.sv
/*
  Self-checking bench: APB master tasks and flag scenarios.
  Assumes the motion core model and a zero-wait APB slave.
*/
`timescale 1ns/1ps
module tb_drive_process_data_status;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        run_request, manual_run, target_arrived, rev_key, fwd_key;
  logic        run_active, rotating, run_start, run_abort, irq;
  logic        invalid_target, invalid_bits, braking, standstill_turned, readjust_active;
  logic [7:0]  paddr;
  logic [15:0] actual_speed, supply_mv, temp_c, control_word, status_word;
  logic [31:0] pwdata, prdata, commanded_pos, actual_pos, answer_id_idx;
  logic [31:0] answer_value, target_value, param_id_idx, param_value, drag_err, v;
  int          bad_count, comparisons;
  // Keys, supply, temperature, expected flags
  logic [41:0] tbl [5] = '{{1'b1, 1'b0, 16'h61A8, 16'h0019, 8'h14},
                           {1'b0, 1'b1, 16'h7918, 16'h0051, 8'h88},
                           {1'b0, 1'b0, 16'h4A38, 16'h004C, 8'h80},
                           {1'b0, 1'b0, 16'h7530, 16'h004B, 8'h00},
                           {1'b0, 1'b0, 16'h61A8, 16'h0019, 8'h10}};

  drive_process_data_status u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .run_request, .manual_run, .target_arrived,
    .invalid_target, .invalid_bits, .run_active, .braking,
    .rotating, .standstill_turned, .readjust_active,
    .commanded_pos, .actual_pos, .actual_speed, .answer_id_idx, .answer_value,
    .rev_key, .fwd_key, .supply_mv, .temp_c, .control_word, .target_value,
    .param_id_idx, .param_value, .run_start, .run_abort, .status_word, .irq);

  motion_core_model u_core (
    .pclk, .presetn, .run_start, .run_abort, .target_arrived, .drag_err,
    .run_active, .rotating, .actual_pos, .commanded_pos);

  // Clock at 50 MHz
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Compare and count
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    v = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(v, e);
  endtask : rd

  // Lets one edge land before a port is sampled
  task settle;
    @(posedge pclk);
    #1;
  endtask : settle

  task report_and_stop;
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // Watchdog
  initial
  begin
    #400000;
    bad_count++;
    report_and_stop;
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {run_request, manual_run, target_arrived, rev_key, fwd_key} = '0;
    {invalid_target, invalid_bits, braking, standstill_turned, readjust_active} = '0;
    supply_mv = 16'h61A8;
    temp_c = 16'h0019;
    actual_speed = 16'h0321;
    answer_id_idx = 32'h0007_0003;
    answer_value = 32'h1357_9BDF;
    drag_err = 32'h0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h24, 32'h0000_0003);
    rd(8'h28, 32'h0064_000A);
    rd(8'h10, 32'h0000_0010);
    wr(8'h00, 32'h0000_0014);
    wr(8'h04, 32'h0000_1234);
    wr(8'h08, 32'h0006_0005);
    wr(8'h0C, 32'hCAFE_0001);
    settle;
    chk({16'h0, control_word}, 32'h0000_0014);
    chk(target_value, 32'h0000_1234);
    chk(param_id_idx, 32'h0006_0005);
    chk(param_value, 32'hCAFE_0001);
    rd(8'h14, 32'h0000_0321);
    rd(8'h18, 32'h0000_1000);
    rd(8'h1C, 32'h0007_0003);
    rd(8'h20, 32'h1357_9BDF);
    for (int i = 0; i < 5; i++)
    begin
      {rev_key, fwd_key, supply_mv, temp_c} <= tbl[i][41:8];
      rd(8'h10, {24'h0, tbl[i][7:0]});
      chk({16'h0, status_word}, {24'h0, tbl[i][7:0]});
    end
    // Run, lag at and past the limit, then release withdrawn
    wr(8'h00, 32'h0000_0010);
    @(posedge pclk);
    run_request <= 1'b1;
    #1 chk({31'h0, run_start}, 32'h1);
    @(posedge pclk);
    run_request <= 1'b0;
    drag_err <= 32'd100;
    rd(8'h10, 32'h0000_0050);
    {braking, drag_err} <= {1'b1, 32'd101};
    rd(8'h10, 32'h0000_0050);
    braking <= 1'b0;
    rd(8'h10, 32'h0000_0052);
    wr(8'h00, 32'h0000_0000);
    drag_err <= 32'h0;
    #1 chk({31'h0, run_abort}, 32'h1);
    rd(8'h10, 32'h0000_0032);
    wr(8'h00, 32'h0000_4000);
    rd(8'h10, 32'h0000_0010);
    // Abort on invalid bits, then arrival, window edge, clear sources
    wr(8'h00, 32'h0000_0014);
    run_request <= 1'b1;
    @(posedge pclk);
    {run_request, invalid_bits} <= 2'b01;
    @(posedge pclk);
    invalid_bits <= 1'b0;
    rd(8'h10, 32'h0000_0030);
    wr(8'h00, 32'h0000_4014);
    @(posedge pclk);
    target_arrived <= 1'b1;
    @(posedge pclk);
    target_arrived <= 1'b0;
    rd(8'h10, 32'h0000_0011);
    wr(8'h04, 32'h0000_100A);
    rd(8'h10, 32'h0000_0011);
    wr(8'h04, 32'h0000_100B);
    rd(8'h10, 32'h0000_0010);
    for (int k = 0; k < 3; k++)
    begin
      target_arrived <= 1'b1;
      @(posedge pclk);
      target_arrived <= 1'b0;
      {manual_run, invalid_target, standstill_turned} <= 3'b100 >> k;
      @(posedge pclk);
      {manual_run, invalid_target, standstill_turned} <= 3'b000;
      rd(8'h10, 32'h0000_0010);
    end
    wr(8'h04, 32'h0000_1005);
    readjust_active <= 1'b1;
    rd(8'h10, 32'h0000_0011);
    readjust_active <= 1'b0;
    // Interrupt masked, unmasked, cleared
    wr(8'h30, 32'h0);
    settle;
    chk({31'h0, irq}, 32'h0);
    wr(8'h30, 32'h1);
    settle;
    chk({31'h0, irq}, 32'h1);
    wr(8'h2C, 32'hFF);
    settle;
    chk({31'h0, irq}, 32'h0);
    rd(8'h2C, 32'h0);
    // Read-only, unmapped, short assemblies
    wr(8'h10, 32'hFF);
    rd(8'h10, 32'h0000_0011);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(8'h24, 32'h0);
    wr(8'h08, 32'h1111_2222);
    settle;
    chk(param_id_idx, 32'h0006_0005);
    rd(8'h20, 32'h0);
    report_and_stop;
  end
endmodule : tb_drive_process_data_status
